// >>> iapc_byte_source.sv
/* Previous pipeline stage model: sends at most one header byte per cycle.
   Assumes the bench fills mem and calls send just after a rising edge. */
module iapc_byte_source (
  input  logic       mclk,
  output logic       inValid,
  output logic       inSof,
  output logic       inEof,
  output logic [7:0] inData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:63];
  // Idle lines at start
  initial begin
    inValid = 1'b0;
    inSof = 1'b0;
    inEof = 1'b0;
    inData = 8'hA5;
  end
  // Frame of n bytes; slow leaves holes inside the frame
  task automatic send(input int n, input bit slow);
    for (int i = 0; i < n; i++) begin
      if (slow && i % 5 == 3) begin
        inValid <= 1'b0;
        inData <= ~inData; // Released data never repeats
        @(posedge mclk);
      end
      inValid <= 1'b1;
      inSof <= (i == 0);
      inEof <= (i == n - 1);
      inData <= mem[i];
      @(posedge mclk);
    end
    inValid <= 1'b0;
    inData <= ~inData;
  endtask
endmodule

// >>> iapc_check_assertions.sv
/* Port assertions for the next-protocol check stage.
   Assumes a bind to the stage, one clock, synchronous reset. */
`include "iapc_defs.vh"
module iapc_check_assertions (
  input logic        mclk,
  input logic        rst,
  input logic [5:0]  regAddr,
  input logic [31:0] regWdata,
  input logic        regWr,
  input logic        regRd,
  input logic [31:0] regRdata,
  input logic        inValid,
  input logic        inEof,
  input logic        chgValid,
  input logic [15:0] chgOld,
  input logic [15:0] chgNew,
  input logic        resValid,
  input logic        resPass,
  input logic        resFlow,
  input logic        resIpsec,
  input logic        noEgressModify,
  input logic [15:0] padWord
);
  timeunit 1ns;
  timeprecision 1ps;
  // End-around carry sum
  function automatic logic [15:0] oadd(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = a + b;
    return s[15:0] + s[16];
  endfunction
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Register port
  a_rd_idle_zero: assert property (!$past(regRd) |-> regRdata == 32'h0)
    else $error("read data without a read");
  // Result timing and holding
  a_res_after_eof: assert property (inValid && inEof |=> resValid)
    else $error("no result after last byte");
  a_res_has_eof: assert property (resValid |-> $past(inValid && inEof))
    else $error("result without last byte");
  a_res_hold: assert property (!resValid |-> $stable({resPass, resFlow, resIpsec}))
    else $error("result changed between frames");
  // Result relations
  a_flow_needs_pass: assert property (resFlow |-> resPass)
    else $error("flow match without pass");
  a_ipsec_pass: assert property (resIpsec |-> resPass)
    else $error("ipsec without pass");
  a_ipsec_no_mod: assert property (noEgressModify == resIpsec)
    else $error("egress flag differs from ipsec");
  // Pad word upkeep
  a_pad_change: assert property (chgValid && !(regWr && regAddr == `IAPC_REG_PAD) |=>
    padWord == oadd(oadd($past(padWord), $past(chgOld)), ~$past(chgNew)))
    else $error("pad word not adjusted");
  a_pad_write: assert property (regWr && regAddr == `IAPC_REG_PAD |=> padWord == 16'($past(regWdata)))
    else $error("pad word not written");
  c_pass: cover property (resValid && resPass);
  c_ipsec: cover property (resValid && resIpsec);
  c_chg: cover property (chgValid);
endmodule

// >>> iapc_defs.vh
/*
  Constants for the IP/ACH next-protocol check stage: register indices,
  field positions, reset values and fixed header offsets.
  Assumes inclusion by bare name from the stage's design file.
*/
`ifndef IAPC_DEFS_VH
`define IAPC_DEFS_VH

// Register indices on the plain register port
`define IAPC_REG_CTRL     6'h00
`define IAPC_REG_MATCH1   6'h01
`define IAPC_REG_M2VAL_HI 6'h02
`define IAPC_REG_M2VAL_LO 6'h03
`define IAPC_REG_M2MSK_HI 6'h04
`define IAPC_REG_M2MSK_LO 6'h05
`define IAPC_REG_OFFSETS  6'h06
`define IAPC_REG_UDP_VAL  6'h07
`define IAPC_REG_UDP_MSK  6'h08
`define IAPC_REG_FLOW_VAL 6'h09
`define IAPC_REG_FLOW_MSK 6'h0D
`define IAPC_REG_STATUS   6'h11
`define IAPC_REG_PAD      6'h12

// Control register fields
`define IAPC_CTRL_MODE_LSB  0
`define IAPC_CTRL_FSEL_LSB  2
`define IAPC_CTRL_FLOW_ENA  4
`define IAPC_CTRL_UDP_ENA   5
`define IAPC_CTRL_TS_CRC    6

// Match 1 fields
`define IAPC_M1_VAL_LSB   0
`define IAPC_M1_MSK_LSB   8
`define IAPC_M1_POS_LSB   16

// Offsets register fields
`define IAPC_OFS_M2POS_LSB 0
`define IAPC_OFS_FLOW_LSB  8
`define IAPC_OFS_NEXT_LSB  16

// Protocol select encodings
`define IAPC_MODE_V4     2'h0
`define IAPC_MODE_V6     2'h1
`define IAPC_MODE_OTH32  2'h2
`define IAPC_MODE_OTH128 2'h3

// Per-flow address select encodings
`define IAPC_FSEL_SRC    2'h0
`define IAPC_FSEL_DST    2'h1
`define IAPC_FSEL_EITHER 2'h2

// Reset values
`define IAPC_RST_CTRL    32'h00000000
`define IAPC_RST_WORD    32'h00000000
`define IAPC_RST_PAD     16'h0000

// Fixed header positions in bytes
`define IAPC_V4_SRC      9'h00C
`define IAPC_V4_DST      9'h010
`define IAPC_V6_SRC      9'h008
`define IAPC_V6_DST      9'h018
`define IAPC_V6_HDR_LEN  8'h28
`define IAPC_FRAG_HI     9'h006
`define IAPC_FRAG_LO     9'h007
`define IAPC_VER_V4      4'h4
`define IAPC_VER_V6      4'h6

`endif

// >>> iapc_next_protocol_check.v
/*
  IP/ACH next-protocol check stage: walks one header byte stream, checks
  version, fragment, header length, two match/mask sets, UDP ports and one
  flow, sums the segment for checksum status and keeps the pad word.
  Assumes the previous stage gives bytes on mclk starting at the IP header
  and a plain register port with read data one cycle after the strobe.
*/
// The address map and the strobed register port were chosen for this implementation.
// Operation
// - IPv6 offset to following protocol checked in bytes, UDP header excluded.
// - With UDP present, source and destination ports checked, one shared setting.
// - Flow match on source, destination or either IPv6 address as configured.
// - Pad word kept valid by adjusting it on every field change, checksum untouched; a pad write in the same cycle as a change wins instead.
// - Checksum is ones' complement of ones' complement sum including pad bytes.
// - IPv6 extension headers are not parsed; such frames are unsupported.
// - ACH checked as protocol only via version, channel type, protocol id.
// - ACH accepted directly after an MPLS label stack, in control word place.
// - IPSec only confirmed present; no egress modification; two-step timestamps only.
// - Ingress IPSec timestamp goes to reserved bytes or over CRC plus new CRC.
// - IPSec presence uses one 64-bit match/mask set over next header, length, SPI.
// - Fields: IPv4 4-bit length, 32-bit address; IPv6 8-bit, 128-bit; ports 32-bit.
// - Two-bit select: IPv4, IPv6, other 32-bit, other 128-bit address match.
// - Version 4 or 6 checked in IPv4 or IPv6 mode; none otherwise.
// - IPv4 matches only with zero fragment offset and zero more-fragments flag.
// - Match set 1 compares one byte; mask bit 1 significant, 0 ignored.
// - Match set 1 starts at a 5-bit offset from the IP header start.
// - Match set 2 is 64-bit, starting at a 7-bit offset from header start.
// - Per-flow select in IPv4/IPv6: source, destination or either address.
`include "iapc_defs.vh"

module iapc_next_protocol_check #(
  parameter CNT_W = 9
) (
  input  wire        mclk,
  input  wire        rst,
  input  wire [5:0]  regAddr,
  input  wire [31:0] regWdata,
  input  wire        regWr,
  input  wire        regRd,
  output reg  [31:0] regRdata,
  input  wire        inValid,
  input  wire        inSof,
  input  wire        inEof,
  input  wire [7:0]  inData,
  input  wire        chgValid,
  input  wire [15:0] chgOld,
  input  wire [15:0] chgNew,
  output reg         resValid,
  output reg         resPass,
  output reg         resFlow,
  output reg         resIpsec,
  output reg  [7:0]  resNextOffset,
  output reg         noEgressModify,
  output reg         tsOverCrc,
  output reg  [15:0] padWord
);

  // Ones' complement 16-bit addition with end-around carry
  function [15:0] onesAdd;
    input [15:0] a;
    input [15:0] b;
    reg   [16:0] s;
    begin
      s = {1'b0, a} + {1'b0, b};
      onesAdd = s[15:0] + {15'h0000, s[16]};
    end
  endfunction

  // Software-visible configuration
  reg  [31:0] ctrl;
  reg  [31:0] match1;
  reg  [63:0] m2Val;
  reg  [63:0] m2Msk;
  reg  [31:0] offsets;
  reg  [31:0] udpVal;
  reg  [31:0] udpMsk;
  reg  [31:0] flowValW [0:3];
  reg  [31:0] flowMskW [0:3];

  wire [1:0]  mode    = ctrl[`IAPC_CTRL_MODE_LSB +: 2];
  wire [1:0]  fSel    = ctrl[`IAPC_CTRL_FSEL_LSB +: 2];
  wire        flowEna = ctrl[`IAPC_CTRL_FLOW_ENA];
  wire        udpEna  = ctrl[`IAPC_CTRL_UDP_ENA];
  wire [7:0]  m1Val   = match1[`IAPC_M1_VAL_LSB +: 8];
  wire [7:0]  m1Msk   = match1[`IAPC_M1_MSK_LSB +: 8];
  wire [4:0]  m1Pos   = match1[`IAPC_M1_POS_LSB +: 5];
  wire [6:0]  m2Pos   = offsets[`IAPC_OFS_M2POS_LSB +: 7];
  wire [4:0]  flowOfs = offsets[`IAPC_OFS_FLOW_LSB +: 5];
  wire [7:0]  nextOfs = offsets[`IAPC_OFS_NEXT_LSB +: 8];
  wire [127:0] flowVal = {flowValW[0], flowValW[1], flowValW[2], flowValW[3]};
  wire [127:0] flowMsk = {flowMskW[0], flowMskW[1], flowMskW[2], flowMskW[3]};

  // Per-frame progress and check flags
  reg  [CNT_W-1:0] byteCnt;
  reg         verOk;
  reg         fragOk;
  reg         lenOk;
  reg         m1Ok;
  reg         m2Ok;
  reg         udpOk;
  reg         srcOk;
  reg         dstOk;
  reg  [15:0] sumAcc;
  reg  [7:0]  sumHi;
  reg  [7:0]  v6NextHdr;
  reg         sumOk;

  wire [CNT_W-1:0] idx = inSof ? {CNT_W{1'b0}} : byteCnt;

  // Flow field placement by protocol select
  // Other modes take the flow field from the programmed offset
  reg  [CNT_W-1:0] srcBase;
  reg  [CNT_W-1:0] dstBase;
  reg  [4:0]       fLen;
  always @* begin
    case (mode)
      `IAPC_MODE_V4: begin
        srcBase = `IAPC_V4_SRC;
        dstBase = `IAPC_V4_DST;
        fLen    = 5'h04;
      end
      `IAPC_MODE_V6: begin
        srcBase = `IAPC_V6_SRC;
        dstBase = `IAPC_V6_DST;
        fLen    = 5'h10;
      end
      `IAPC_MODE_OTH32: begin
        srcBase = {{(CNT_W-5){1'b0}}, flowOfs};
        dstBase = {{(CNT_W-5){1'b0}}, flowOfs};
        fLen    = 5'h04;
      end
      default: begin
        srcBase = {{(CNT_W-5){1'b0}}, flowOfs};
        dstBase = {{(CNT_W-5){1'b0}}, flowOfs};
        fLen    = 5'h10;
      end
    endcase
  end

  // Byte distances from each field start
  // Distances wrap below a field start; the >= tests mask that
  wire [CNT_W-1:0] d2   = idx - {{(CNT_W-7){1'b0}}, m2Pos};
  wire [CNT_W-1:0] dSrc = idx - srcBase;
  wire [CNT_W-1:0] dDst = idx - dstBase;
  wire [CNT_W-1:0] dUdp = idx - {{(CNT_W-8){1'b0}}, nextOfs};
  wire in2   = (idx >= {{(CNT_W-7){1'b0}}, m2Pos}) && (d2 < 8);
  wire inSrc = (idx >= srcBase) && (dSrc < {{(CNT_W-5){1'b0}}, fLen});
  wire inDst = (idx >= dstBase) && (dDst < {{(CNT_W-5){1'b0}}, fLen});
  wire inUdp = (idx >= {{(CNT_W-8){1'b0}}, nextOfs}) && (dUdp < 4);

  // Reference bytes, most significant byte first on the wire
  wire [7:0] m2V  = m2Val[8*(7-d2[2:0]) +: 8];
  wire [7:0] m2M  = m2Msk[8*(7-d2[2:0]) +: 8];
  wire [7:0] sV   = flowVal[8*(15-dSrc[3:0]) +: 8];
  wire [7:0] sM   = flowMsk[8*(15-dSrc[3:0]) +: 8];
  wire [7:0] dV   = flowVal[8*(15-dDst[3:0]) +: 8];
  wire [7:0] dM   = flowMsk[8*(15-dDst[3:0]) +: 8];
  wire [7:0] uV   = udpVal[8*(3-dUdp[1:0]) +: 8];
  wire [7:0] uM   = udpMsk[8*(3-dUdp[1:0]) +: 8];
  wire       isV4 = (mode == `IAPC_MODE_V4);
  wire       isV6 = (mode == `IAPC_MODE_V6);

  // Per-byte hits; a byte outside a field never spoils it
  // Version and length sit in byte 0, fragment bits in bytes 6 and 7
  wire hitM1  = (idx != {{(CNT_W-5){1'b0}}, m1Pos}) || (((inData ^ m1Val) & m1Msk) == 8'h00);
  wire hitM2  = !in2 || (((inData ^ m2V) & m2M) == 8'h00);
  wire hitSrc = !inSrc || (((inData ^ sV) & sM) == 8'h00);
  wire hitDst = !inDst || (((inData ^ dV) & dM) == 8'h00);
  wire hitUdp = !inUdp || (((inData ^ uV) & uM) == 8'h00);
  wire atVer  = (idx == {CNT_W{1'b0}});
  wire hitVer = !atVer || (isV4 ? (inData[7:4] == `IAPC_VER_V4) :
                isV6 ? (inData[7:4] == `IAPC_VER_V6) : 1'b1);
  wire hitFrg = !isV4 || ((idx != `IAPC_FRAG_HI || inData[5:0] == 6'h00) &&
                (idx != `IAPC_FRAG_LO || inData == 8'h00));
  wire hitLen = !isV4 || !atVer || ({2'b00, inData[3:0], 2'b00} == nextOfs);

  // Running segment sum, bytes paired high then low
  wire [15:0] sumWord = idx[0] ? {sumHi, inData} : {inData, 8'h00};
  wire [15:0] sumBase = inSof ? 16'h0000 : (idx[0] ? sumAcc : sumAcc);
  wire [15:0] sumPrev = idx[0] ? onesAdd(sumBase, {8'h00 - 8'h00, 8'h00}) : sumBase;
  wire [15:0] sumNext = idx[0] ? onesAdd(sumPrev, sumWord) : sumPrev;
  wire [15:0] sumEnd  = idx[0] ? sumNext : onesAdd(sumPrev, sumWord);

  // Frame walk: counter, check flags and sum
  // Flags restart on inSof and only fall while a frame runs
  always @(posedge mclk) begin
    if (rst) begin
      byteCnt   <= {CNT_W{1'b0}};
      verOk     <= 1'b1;
      fragOk    <= 1'b1;
      lenOk     <= 1'b1;
      m1Ok      <= 1'b1;
      m2Ok      <= 1'b1;
      udpOk     <= 1'b1;
      srcOk     <= 1'b1;
      dstOk     <= 1'b1;
      sumAcc    <= 16'h0000;
      sumHi     <= 8'h00;
      v6NextHdr <= 8'h00;
    end else if (inValid) begin
      if (idx != {CNT_W{1'b1}})
        byteCnt <= idx + 1'b1;
      verOk  <= (inSof | verOk) & hitVer;
      fragOk <= (inSof | fragOk) & hitFrg;
      lenOk  <= (inSof | lenOk) & hitLen;
      m1Ok   <= (inSof | m1Ok) & hitM1;
      m2Ok   <= (inSof | m2Ok) & hitM2;
      udpOk  <= (inSof | udpOk) & hitUdp;
      srcOk  <= (inSof | srcOk) & hitSrc;
      dstOk  <= (inSof | dstOk) & hitDst;
      if (!idx[0])
        sumHi <= inData;
      else
        sumAcc <= sumNext;
      if (inSof)
        sumAcc <= 16'h0000;
      if (idx == `IAPC_FRAG_HI)
        v6NextHdr <= inData;
    end
  end

  // Final verdict for the byte closing the frame
  // Stored flags merge with the current byte, so one-byte frames work too
  wire fVer  = (inSof | verOk) & hitVer;
  wire fFrg  = (inSof | fragOk) & hitFrg;
  // IPv6 header has a fixed length, so the offset must be exactly 40 bytes
  wire fHlen = ((inSof | lenOk) & hitLen) &&
               (!isV6 || nextOfs == `IAPC_V6_HDR_LEN);
  wire fM1   = (inSof | m1Ok) & hitM1;
  wire fM2   = (inSof | m2Ok) & hitM2;
  wire fUdp  = !udpEna || ((inSof | udpOk) & hitUdp);
  wire fSrc  = (inSof | srcOk) & hitSrc;
  wire fDst  = (inSof | dstOk) & hitDst;
  wire pass  = fVer & fFrg & fHlen & fM1 & fM2 & fUdp;
  reg  flowHit;
  always @* begin
    if (!isV4 && !isV6)
      flowHit = fSrc;
    else begin
      case (fSel)
        `IAPC_FSEL_SRC:    flowHit = fSrc;
        `IAPC_FSEL_DST:    flowHit = fDst;
        `IAPC_FSEL_EITHER: flowHit = fSrc | fDst;
        default:           flowHit = 1'b0;
      endcase
    end
  end
  wire ipsecHit = (isV4 | isV6) && (m2Msk != 64'h0) && fM2;

  // Result toward the next comparator, one pulse per frame end
  // Result bits hold between pulses for the status register
  always @(posedge mclk) begin
    if (rst) begin
      resValid       <= 1'b0;
      resPass        <= 1'b0;
      resFlow        <= 1'b0;
      resIpsec       <= 1'b0;
      resNextOffset  <= 8'h00;
      noEgressModify <= 1'b0;
      sumOk          <= 1'b0;
    end else begin
      resValid <= inValid & inEof;
      if (inValid && inEof) begin
        resPass        <= pass;
        resFlow        <= pass & flowEna & flowHit;
        resIpsec       <= pass & ipsecHit;
        resNextOffset  <= nextOfs;
        noEgressModify <= pass & ipsecHit;
        sumOk          <= (sumEnd == 16'hFFFF);
      end
    end
  end

  // Pad word follows every field change so the checksum stays put
  // A software write in the same cycle as a change wins
  always @(posedge mclk) begin
    if (rst)
      padWord <= `IAPC_RST_PAD;
    else if (regWr && regAddr == `IAPC_REG_PAD)
      padWord <= regWdata[15:0];
    else if (chgValid)
      padWord <= onesAdd(onesAdd(padWord, chgOld), ~chgNew);
  end

  // Timestamp placement choice for ingress IPSec frames
  // Only steers the later rewriter; this stage never edits the frame
  always @(posedge mclk) begin
    if (rst)
      tsOverCrc <= 1'b0;
    else
      tsOverCrc <= ctrl[`IAPC_CTRL_TS_CRC];
  end

  // Register writes
  // Reserved bits are stored as zero so reads return zero
  integer i;
  always @(posedge mclk) begin
    if (rst) begin
      ctrl    <= `IAPC_RST_CTRL;
      match1  <= `IAPC_RST_WORD;
      m2Val   <= {`IAPC_RST_WORD, `IAPC_RST_WORD};
      m2Msk   <= {`IAPC_RST_WORD, `IAPC_RST_WORD};
      offsets <= `IAPC_RST_WORD;
      udpVal  <= `IAPC_RST_WORD;
      udpMsk  <= `IAPC_RST_WORD;
      for (i = 0; i < 4; i = i + 1) begin
        flowValW[i] <= `IAPC_RST_WORD;
        flowMskW[i] <= `IAPC_RST_WORD;
      end
    end else if (regWr) begin
      case (regAddr)
        `IAPC_REG_CTRL:     ctrl <= {25'h0000000, regWdata[6:0]};
        `IAPC_REG_MATCH1:   match1 <= {11'h000, regWdata[20:0]};
        `IAPC_REG_M2VAL_HI: m2Val[63:32] <= regWdata;
        `IAPC_REG_M2VAL_LO: m2Val[31:0] <= regWdata;
        `IAPC_REG_M2MSK_HI: m2Msk[63:32] <= regWdata;
        `IAPC_REG_M2MSK_LO: m2Msk[31:0] <= regWdata;
        `IAPC_REG_OFFSETS:  offsets <= {8'h00, regWdata[23:16], 3'h0,
                                        regWdata[12:8], 1'b0, regWdata[6:0]};
        `IAPC_REG_UDP_VAL:  udpVal <= regWdata;
        `IAPC_REG_UDP_MSK:  udpMsk <= regWdata;
        default: begin
          for (i = 0; i < 4; i = i + 1) begin
            if (regAddr == `IAPC_REG_FLOW_VAL + i[5:0])
              flowValW[i] <= regWdata;
            if (regAddr == `IAPC_REG_FLOW_MSK + i[5:0])
              flowMskW[i] <= regWdata;
          end
        end
      endcase
    end
  end

  // Read mux, unmapped addresses read zero
  // Own loop index, so the write process stays the only driver of i
  integer    j;
  reg [31:0] rdMux;
  always @* begin
    rdMux = 32'h00000000;
    case (regAddr)
      `IAPC_REG_CTRL:     rdMux = ctrl;
      `IAPC_REG_MATCH1:   rdMux = match1;
      `IAPC_REG_M2VAL_HI: rdMux = m2Val[63:32];
      `IAPC_REG_M2VAL_LO: rdMux = m2Val[31:0];
      `IAPC_REG_M2MSK_HI: rdMux = m2Msk[63:32];
      `IAPC_REG_M2MSK_LO: rdMux = m2Msk[31:0];
      `IAPC_REG_OFFSETS:  rdMux = offsets;
      `IAPC_REG_UDP_VAL:  rdMux = udpVal;
      `IAPC_REG_UDP_MSK:  rdMux = udpMsk;
      `IAPC_REG_STATUS:   rdMux = {16'h0000, v6NextHdr, 3'h0, sumOk,
                                   resIpsec, resFlow, resPass, 1'b0};
      `IAPC_REG_PAD:      rdMux = {16'h0000, padWord};
      default: begin
        for (j = 0; j < 4; j = j + 1) begin
          if (regAddr == `IAPC_REG_FLOW_VAL + j[5:0])
            rdMux = flowValW[j];
          if (regAddr == `IAPC_REG_FLOW_MSK + j[5:0])
            rdMux = flowMskW[j];
        end
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge mclk) begin
    if (rst)
      regRdata <= 32'h00000000;
    else if (regRd)
      regRdata <= rdMux;
    else
      regRdata <= 32'h00000000;
  end

endmodule

// >>> iapc_next_protocol_check_tb.sv
/* Self-checking bench for the next-protocol check stage.
   Assumes the design, its defs header, the checker and the byte source. */
`include "iapc_defs.vh"
bind iapc_next_protocol_check iapc_check_assertions chk (.mclk(mclk), .rst(rst), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .inValid(inValid),
  .inEof(inEof), .chgValid(chgValid), .chgOld(chgOld), .chgNew(chgNew), .resValid(resValid),
  .resPass(resPass), .resFlow(resFlow), .resIpsec(resIpsec), .noEgressModify(noEgressModify),
  .padWord(padWord));
module iapc_next_protocol_check_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic         mclk, rst, regWr, regRd, chgValid, inValid, inSof, inEof;
  logic         resValid, resPass, resFlow, resIpsec, noEgr, tsOverCrc, fOn, udp, ts;
  logic [5:0]   regAddr;
  logic [31:0]  regWdata, regRdata, uv;
  logic [15:0]  chgOld, chgNew, padWord, pe;
  logic [7:0]   inData, resNext, m1v, m1k, nxt;
  logic [7:0]   hb [0:63];
  logic [1:0]   mode, fsel;
  logic [2:0]   ex;
  logic [4:0]   m1p, fo;
  logic [6:0]   m2p;
  logic [63:0]  m2v, m2k;
  logic [127:0] fv;
  int           error_cnt, num_checks, seed, cyc, n, w, b;
  iapc_next_protocol_check dut (.mclk(mclk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .inValid(inValid), .inSof(inSof),
    .inEof(inEof), .inData(inData), .chgValid(chgValid), .chgOld(chgOld), .chgNew(chgNew),
    .resValid(resValid), .resPass(resPass), .resFlow(resFlow), .resIpsec(resIpsec),
    .resNextOffset(resNext), .noEgressModify(noEgr), .tsOverCrc(tsOverCrc), .padWord(padWord));
  iapc_byte_source src (.mclk(mclk), .inValid(inValid), .inSof(inSof), .inEof(inEof), .inData(inData));
  // Clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end
  function automatic logic [15:0] oadd(input logic [15:0] a, input logic [15:0] c);
    logic [16:0] s;
    s = a + c;
    return s[15:0] + s[16];
  endfunction
  // Ones' complement sum of the first m bytes of hb, paired high then low
  function automatic logic [15:0] osum(input int m);
    logic [15:0] s;
    s = 16'h0;
    for (int i = 0; i < m; i += 2) s = oadd(s, {hb[i], hb[i + 1]});
    return s;
  endfunction
  // Expected {ipsec, flow, pass} for the frame in hb
  function automatic logic [2:0] expRes();
    logic ok, m2, fs, fd;
    ok = mode[1] || hb[0][7:4] == (mode[0] ? 4'h6 : 4'h4);
    if (mode == 2'h0) ok &= hb[0][3:0] * 4 == nxt && hb[6][5:0] == 6'h0 && hb[7] == 8'h0;
    ok &= ((hb[m1p] ^ m1v) & m1k) == 8'h0;
    m2 = 1'b1;
    fs = 1'b1;
    fd = 1'b1;
    for (int i = 0; i < 16; i++) begin
      if (i < 8) m2 &= ((hb[m2p + i] ^ m2v[63 - 8 * i -: 8]) & m2k[63 - 8 * i -: 8]) == 8'h0;
      if (i < 4 && udp) ok &= hb[nxt + i] == uv[31 - 8 * i -: 8];
      if (i < (mode[0] ? 16 : 4)) fs &= hb[(mode[1] ? fo : mode[0] ? 8 : 12) + i] == fv[127 - 8 * i -: 8];
      if (i < (mode[0] ? 16 : 4)) fd &= hb[(mode[0] ? 24 : 16) + i] == fv[127 - 8 * i -: 8];
    end
    ok &= m2;
    return {ok && m2k != 64'h0 && !mode[1],
            ok && fOn && ((mode[1] || fsel == 2'h0) ? fs : fsel == 2'h1 ? fd : fs | fd), ok};
  endfunction
  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wr(input logic [5:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
    @(posedge mclk);
  endtask
  task rd(input logic [5:0] a, input logic [31:0] e);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 chk(regRdata, e);
    @(posedge mclk);
  endtask
  task wrap_up;
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    {rst, regWr, regRd, chgValid, regAddr, regWdata, chgOld, chgNew} = 'h0;
    rst = 1'b1;
    seed = 29;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    rd(`IAPC_REG_CTRL, 32'h0);
    rd(`IAPC_REG_PAD, 32'h0);
    wr(6'h3F, 32'hFFFFFFFF);
    rd(6'h3F, 32'h0);
    wr(`IAPC_REG_CTRL, 32'hFFFFFFFF);
    rd(`IAPC_REG_CTRL, 32'h0000007F);
    pe = $random(seed);
    wr(`IAPC_REG_PAD, {16'h0, pe});
    for (int i = 0; i < 8; i++) begin
      chgOld <= $random(seed);
      chgNew <= $random(seed);
      chgValid <= 1'b1;
      regWr <= (i == 7); // Last change collides with a pad write
      regAddr <= `IAPC_REG_PAD;
      regWdata <= 32'h00001234;
      @(posedge mclk);
      chgValid <= 1'b0;
      regWr <= 1'b0;
      #1 pe = (i == 7) ? 16'h1234 : oadd(oadd(pe, chgOld), ~chgNew);
      chk(padWord, pe);
      @(posedge mclk);
    end
    for (int k = 0; k < 32; k++) begin
      mode = k[1:0];
      fsel = 2'(k / 4 % 3);
      ts = $random(seed);
      fOn = k % 8 != 2;
      udp = !mode[1];
      for (int i = 0; i < 64; i++) hb[i] = $random(seed);
      n = mode == 2'h1 ? 48 : 28;
      nxt = mode == 2'h1 ? 8'h28 : 8'h14;
      hb[0] = mode == 2'h1 ? {4'h6, hb[0][3:0]} : 8'h45;
      if (mode == 2'h0) {hb[6][5:0], hb[7]} = 14'h0;
      {hb[n - 2], hb[n - 1]} = ~osum(n - 2);
      m1p = mode == 2'h0 ? 5'h09 : 5'h06;
      m1v = hb[m1p];
      m1k = $random(seed);
      m2p = nxt[6:0];
      m2k = (k % 4 == 3 || k % 8 == 4) ? 64'h0 : {$random(seed), $random(seed)};
      b = k[2] ? (mode[0] ? 24 : 16) : (mode[0] ? 8 : 12);
      fo = b[4:0];
      fv = 128'h0;
      for (int i = 0; i < 16; i++) begin
        if (i < 8) m2v[63 - 8 * i -: 8] = hb[m2p + i];
        if (i < 4) uv[31 - 8 * i -: 8] = hb[nxt + i];
        if (i < (mode[0] ? 16 : 4)) fv[127 - 8 * i -: 8] = hb[b + i];
      end
      case (k % 6)
        1: hb[0] ^= 8'h80;
        2: hb[6] ^= 8'h20;
        3: hb[m1p] ^= 8'hFF;
        4: hb[nxt + 1] ^= 8'h01;
        5: hb[b + 3] ^= 8'h10;
        default: ;
      endcase
      wr(`IAPC_REG_CTRL, {25'h0, ts, udp, fOn, fsel, mode});
      wr(`IAPC_REG_MATCH1, {11'h0, m1p, m1k, m1v});
      rd(`IAPC_REG_MATCH1, {11'h0, m1p, m1k, m1v});
      wr(`IAPC_REG_M2VAL_HI, m2v[63:32]);
      wr(`IAPC_REG_M2VAL_LO, m2v[31:0]);
      wr(`IAPC_REG_M2MSK_HI, m2k[63:32]);
      wr(`IAPC_REG_M2MSK_LO, m2k[31:0]);
      wr(`IAPC_REG_OFFSETS, {8'h0, nxt, 3'h0, fo, 1'h0, m2p});
      wr(`IAPC_REG_UDP_VAL, uv);
      wr(`IAPC_REG_UDP_MSK, 32'hFFFFFFFF);
      for (int i = 0; i < 4; i++) begin
        wr(6'(`IAPC_REG_FLOW_VAL + i), fv[127 - 32 * i -: 32]);
        wr(6'(`IAPC_REG_FLOW_MSK + i), 32'hFFFFFFFF);
      end
      for (int i = 0; i < 64; i++) src.mem[i] = hb[i];
      src.send(n, k[0]);
      w = 0;
      #1;
      while (resValid !== 1'b1 && w < 5) begin
        @(posedge mclk);
        #1 w++;
      end
      chk(resValid, 1'b1);
      ex = expRes();
      chk({resIpsec, resFlow, resPass}, ex);
      chk(resNext, nxt);
      chk({noEgr, tsOverCrc}, {ex[2], ts});
      rd(`IAPC_REG_STATUS, {16'h0, hb[6], 3'h0, osum(n) == 16'hFFFF, ex, 1'b0});
    end
    wrap_up();
  end
endmodule
